/* File: hw/emb_pkg.sv */
/*
  package for the external memory byte lane and address map block:
  field widths, package and width selectors, request carrier.
  assumes one clock and a synchronous active-high reset.
*/
package emb_pkg;
  localparam int ADDR_W    = 21;
  localparam int DATA_W    = 16;
  localparam int PIN_A_HI  = 20;
  localparam int SML_A_TOP = 13;
  localparam int SML_A_X   = 14;
  localparam int BYTE_W    = 8;
  localparam logic [1:0] LANES_OFF   = 2'h3;
  localparam logic [1:0] LANES_BOTH  = 2'h0;
  localparam logic [1:0] LANE_LOWER  = 2'h2;
  localparam logic [1:0] LANE_UPPER  = 2'h1;

  typedef struct packed {
    logic                go;
    logic                wr;
    logic                is_byte;
    logic                sdram;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata;
  } emb_req_t;

  typedef struct packed {
    logic                large_pkg;
    logic                mem8;
    logic                restrict8;
    logic                keepers;
    logic                hold;
  } emb_cfg_t;
endpackage

/* File: hw/emb_addr_map.sv */
/*
  address pin mapper: internal byte address to external address pins.
  assumes package and memory width are static configuration.
*/
`timescale 1ns/1ps
module emb_addr_map
  import emb_pkg::*;
(
  // configuration
  input  wire logic                large_pkg,
  input  wire logic                mem8,
  // address in
  input  wire logic [ADDR_W-1:0]   addr,
  // pins out
  output logic      [PIN_A_HI:0]   pins,
  output logic                     extra_pin
);
  logic [PIN_A_HI:0] small_map;
  logic [PIN_A_HI:0] large_map;
  // low pin gets bit 0 on x8, bit 14 on x16
  assign small_map = {{(PIN_A_HI-SML_A_TOP){1'b0}}, addr[SML_A_TOP:1],
                      mem8 ? addr[0] : addr[SML_A_X]};
  // low pin unused; bit 0 goes to the extra pin on x8, which stays low on x16
  assign large_map = {addr[PIN_A_HI:1], 1'b0};
  assign pins      = large_pkg ? large_map : small_map;
  assign extra_pin = large_pkg & mem8 & addr[0];
endmodule

/* File: hw/emb_lane_ctrl.sv */
/*
  byte lane strobes, data bus direction, keepers and hold release for
  an external memory interface.
  assumes the requester issues one-cycle requests on CLOCK and that the
  register port is a plain strobe port with read data a cycle later.
*/
`timescale 1ns/1ps
module emb_lane_ctrl
  import emb_pkg::*;
(
  // clock and reset
  input  wire logic                CLOCK,
  input  wire logic                RST,
  // register port
  input  wire logic [1:0]          REG_ADDR,
  input  wire logic [7:0]          REG_WDATA,
  input  wire logic                REG_WR,
  input  wire logic                REG_RD,
  output logic      [7:0]          REG_RDATA,
  // access request
  input  wire emb_req_t            REQ,
  output logic                     REQ_REJECT,
  output logic      [BYTE_W*2-1:0] RD_DATA,
  output logic                     RD_VALID,
  // pins
  output logic      [PIN_A_HI:0]   ADDR_PINS,
  output logic                     EXTRA_LOW_BYTE_ADDR_PIN,
  output logic                     ADDR_OE_N,
  output logic                     UPPER_LANE_STROBE_N,
  output logic                     LOWER_LANE_STROBE_N,
  output logic                     STROBE_OE_N,
  output logic      [DATA_W-1:0]   DATA_OUT,
  output logic      [DATA_W-1:0]   DATA_OE_N,
  input  wire logic [DATA_W-1:0]   DATA_IN,
  output logic                     KEEPER_EN
);
  // -------------------------------------------------------------------
  // register port
  // -------------------------------------------------------------------
  localparam logic [1:0] REG_BUS_SEL = 2'h0;
  localparam logic [1:0] REG_CONFIG  = 2'h1;
  localparam logic [1:0] REG_STATUS  = 2'h2;
  localparam int B_HOLD = 0;
  localparam int B_PKG  = 0;
  localparam int B_M8   = 1;
  localparam int B_RES  = 2;
  localparam int B_KEEP = 3;
  localparam int B_CLR  = 1;
  localparam int RD_LAT = 4;

  emb_cfg_t cfg_q, cfg_d;
  logic [7:0] rdata_d, rdata_q;
  logic       rej_q, busy_q;
  wire        wr_sel = REG_WR & (REG_ADDR == REG_BUS_SEL);
  wire        wr_cfg = REG_WR & (REG_ADDR == REG_CONFIG);

  always_comb begin
    cfg_d = cfg_q;
    if (wr_sel) begin
      cfg_d.hold = REG_WDATA[B_HOLD];
    end
    if (wr_cfg) begin
      cfg_d.large_pkg = REG_WDATA[B_PKG];
      cfg_d.mem8      = REG_WDATA[B_M8];
      cfg_d.restrict8 = REG_WDATA[B_RES];
      cfg_d.keepers   = REG_WDATA[B_KEEP];
    end
  end

  assign rdata_d =
    (REG_ADDR == REG_BUS_SEL) ? {7'h00, cfg_q.hold} :
    (REG_ADDR == REG_CONFIG)  ? {4'h0, cfg_q.keepers, cfg_q.restrict8,
                                 cfg_q.mem8, cfg_q.large_pkg} :
    (REG_ADDR == REG_STATUS)  ? {6'h00, busy_q, rej_q} : 8'h00;

  // -------------------------------------------------------------------
  // request decode
  // -------------------------------------------------------------------
  // restricted parts take only async reads on x8 memory
  wire bad8   = cfg_q.restrict8 & cfg_q.mem8 &
                (REQ.wr | REQ.sdram);
  // a hold written in the same cycle already blocks the request
  wire accept = REQ.go & ~cfg_d.hold & ~bad8;
  wire reject = REQ.go & (cfg_d.hold | bad8);

  logic [1:0] lanes_n;
  // x8 uses the lower lane only; x16 byte writes pick by addr[0]
  assign lanes_n =
    cfg_q.mem8                ? LANE_LOWER :
    (REQ.wr & REQ.is_byte)    ? (REQ.addr[0] ? LANE_UPPER
                                             : LANE_LOWER) :
    LANES_BOTH;

  logic [DATA_W-1:0] wdata_lane;
  assign wdata_lane =
    (~cfg_q.mem8 & REQ.is_byte & REQ.addr[0]) ?
      {REQ.wdata[BYTE_W-1:0], REQ.wdata[BYTE_W-1:0]} : REQ.wdata;

  logic [DATA_W-1:0] oe_mask_n;
  assign oe_mask_n = cfg_q.mem8 ? {{BYTE_W{1'b1}}, {BYTE_W{1'b0}}} :
                     {lanes_n[1] ? {BYTE_W{1'b1}} : {BYTE_W{1'b0}},
                      lanes_n[0] ? {BYTE_W{1'b1}} : {BYTE_W{1'b0}}};

  logic [PIN_A_HI:0] apins;
  logic              xpin;
  emb_addr_map u_map (
    .large_pkg (cfg_q.large_pkg),
    .mem8      (cfg_q.mem8),
    .addr      (REQ.addr),
    .pins      (apins),
    .extra_pin (xpin)
  );

  // -------------------------------------------------------------------
  // read capture and unpack
  // -------------------------------------------------------------------
  logic [DATA_W-1:0] din_s1, din_s2;
  logic              rd_p1, rd_p2, sel_hi_p1, sel_hi_p2, byte_p1, byte_p2;
  logic              rd_p3, sel_hi_p3, byte_p3;
  logic [DATA_W-1:0] rd_unpacked;
  // requested byte taken from the full word
  assign rd_unpacked =
    ~byte_p3     ? din_s2 :
    sel_hi_p3    ? {{BYTE_W{1'b0}}, din_s2[DATA_W-1:BYTE_W]} :
                   {{BYTE_W{1'b0}}, din_s2[BYTE_W-1:0]};

  // -------------------------------------------------------------------
  // pin registers
  // -------------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      cfg_q                   <= '0;
      rdata_q                 <= 8'h00;
      rej_q                   <= 1'b0;
      busy_q                  <= 1'b0;
      ADDR_PINS               <= '0;
      EXTRA_LOW_BYTE_ADDR_PIN <= 1'b0;
      UPPER_LANE_STROBE_N     <= 1'b1;
      LOWER_LANE_STROBE_N     <= 1'b1;
      DATA_OUT                <= '0;
      DATA_OE_N               <= '1;
      ADDR_OE_N               <= 1'b0;
      STROBE_OE_N             <= 1'b0;
      KEEPER_EN               <= 1'b0;
      din_s1                  <= '0;
      din_s2                  <= '0;
      rd_p1                   <= 1'b0;
      rd_p2                   <= 1'b0;
      sel_hi_p1               <= 1'b0;
      sel_hi_p2               <= 1'b0;
      byte_p1                 <= 1'b0;
      byte_p2                 <= 1'b0;
      rd_p3                   <= 1'b0;
      sel_hi_p3               <= 1'b0;
      byte_p3                 <= 1'b0;
    end else begin
      cfg_q   <= cfg_d;
      rdata_q <= REG_RD ? rdata_d : 8'h00;
      // status sticky: a new reject wins over the clear
      rej_q   <= reject | (rej_q & ~(wr_sel & REG_WDATA[B_CLR]));
      busy_q  <= accept;
      if (accept) begin
        ADDR_PINS               <= apins;
        EXTRA_LOW_BYTE_ADDR_PIN <= xpin;
      end
      UPPER_LANE_STROBE_N <= accept ? lanes_n[1] : 1'b1;
      LOWER_LANE_STROBE_N <= accept ? lanes_n[0] : 1'b1;
      if (accept & REQ.wr) begin
        DATA_OUT <= wdata_lane;
      end
      // drive only during a write transfer
      DATA_OE_N   <= (accept & REQ.wr) ? oe_mask_n : '1;
      ADDR_OE_N   <= cfg_d.hold;
      STROBE_OE_N <= cfg_d.hold;
      KEEPER_EN   <= cfg_d.keepers & ~cfg_d.hold;
      din_s1      <= DATA_IN;
      din_s2      <= din_s1;
      rd_p1       <= accept & ~REQ.wr;
      rd_p2       <= rd_p1;
      sel_hi_p1   <= REQ.addr[0] & ~cfg_q.mem8;
      sel_hi_p2   <= sel_hi_p1;
      byte_p1     <= REQ.is_byte | cfg_q.mem8;
      byte_p2     <= byte_p1;
      // third stage lines the flags up with the twice-synced pin data
      rd_p3       <= rd_p2;
      sel_hi_p3   <= sel_hi_p2;
      byte_p3     <= byte_p2;
    end
  end

  logic [DATA_W-1:0] rd_data_q;
  logic              rd_valid_q;
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      rd_data_q  <= '0;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= rd_p3;
      if (rd_p3) begin
        rd_data_q <= rd_unpacked;
      end
    end
  end
  assign RD_DATA    = rd_data_q;
  assign RD_VALID   = rd_valid_q;
  assign REG_RDATA  = rdata_q;
  assign REQ_REJECT = rej_q;

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  property p_byte_wr_one_lane;
    @(posedge CLOCK) disable iff (RST)
    (accept & REQ.wr & REQ.is_byte & ~cfg_q.mem8) |=>
      (UPPER_LANE_STROBE_N ^ LOWER_LANE_STROBE_N);
  endproperty
  a_byte_wr_one_lane: assert property (p_byte_wr_one_lane)
    else $error("byte write did not use exactly one lane");

  property p_byte_rd_both;
    @(posedge CLOCK) disable iff (RST)
    (accept & ~REQ.wr & ~cfg_q.mem8) |=>
      (~UPPER_LANE_STROBE_N & ~LOWER_LANE_STROBE_N);
  endproperty
  a_byte_rd_both: assert property (p_byte_rd_both)
    else $error("x16 read did not assert both lanes");

  property p_x8_lower;
    @(posedge CLOCK) disable iff (RST)
    (accept & cfg_q.mem8) |=>
      (UPPER_LANE_STROBE_N & &DATA_OE_N[DATA_W-1:BYTE_W]);
  endproperty
  a_x8_lower: assert property (p_x8_lower)
    else $error("x8 access touched upper lane");

  property p_release;
    @(posedge CLOCK) disable iff (RST)
    !(accept & REQ.wr) |=> (&DATA_OE_N);
  endproperty
  a_release: assert property (p_release)
    else $error("data bus driven outside write");

  property p_keep;
    @(posedge CLOCK) disable iff (RST)
    (cfg_q.keepers & ~cfg_q.hold & ~wr_cfg & ~wr_sel) |=> KEEPER_EN;
  endproperty
  a_keep: assert property (p_keep)
    else $error("keepers not enabled");

  property p_nokeep;
    @(posedge CLOCK) disable iff (RST)
    !cfg_q.keepers |-> !KEEPER_EN;
  endproperty
  a_nokeep: assert property (p_nokeep)
    else $error("keepers on while disabled");

  property p_hold;
    @(posedge CLOCK) disable iff (RST)
    (wr_sel & REG_WDATA[B_HOLD]) |=> ADDR_OE_N & STROBE_OE_N & (&DATA_OE_N);
  endproperty
  a_hold: assert property (p_hold)
    else $error("pins not released under hold");

  property p_small_map;
    @(posedge CLOCK) disable iff (RST)
    (accept & ~cfg_q.large_pkg & ~cfg_q.mem8) |=>
      ADDR_PINS[0] == $past(REQ.addr[SML_A_X]);
  endproperty
  a_small_map: assert property (p_small_map)
    else $error("small package low pin wrong");

  property p_large_map;
    @(posedge CLOCK) disable iff (RST)
    (accept & cfg_q.large_pkg) |=>
      ADDR_PINS[0] == 1'b0 &&
      ADDR_PINS[PIN_A_HI:1] == $past(REQ.addr[PIN_A_HI:1]);
  endproperty
  a_large_map: assert property (p_large_map)
    else $error("large package mapping wrong");

  property p_restrict;
    @(posedge CLOCK) disable iff (RST)
    (REQ.go & cfg_q.restrict8 & cfg_q.mem8 & REQ.wr) |=>
      (UPPER_LANE_STROBE_N & LOWER_LANE_STROBE_N & REQ_REJECT);
  endproperty
  a_restrict: assert property (p_restrict)
    else $error("restricted x8 write issued");

  property p_lane_pick;
    @(posedge CLOCK) disable iff (RST)
    (accept & REQ.wr & REQ.is_byte & ~cfg_q.mem8) |=>
      UPPER_LANE_STROBE_N == !$past(REQ.addr[0]);
  endproperty
  a_lane_pick: assert property (p_lane_pick)
    else $error("wrong lane for byte write");

  property p_rd_latency;
    @(posedge CLOCK) disable iff (RST)
    (accept & ~REQ.wr) |-> ##RD_LAT RD_VALID;
  endproperty
  a_rd_latency: assert property (p_rd_latency)
    else $error("read data not returned on time");

  property p_hold_quiet;
    @(posedge CLOCK) disable iff (RST)
    cfg_d.hold |=> ADDR_OE_N & STROBE_OE_N & UPPER_LANE_STROBE_N &
                   LOWER_LANE_STROBE_N & (&DATA_OE_N);
  endproperty
  a_hold_quiet: assert property (p_hold_quiet)
    else $error("pins active while hold set");

  property p_small_map8;
    @(posedge CLOCK) disable iff (RST)
    (accept & ~cfg_q.large_pkg & cfg_q.mem8) |=>
      ADDR_PINS[0] == $past(REQ.addr[0]);
  endproperty
  a_small_map8: assert property (p_small_map8)
    else $error("small package x8 low pin wrong");

  property p_extra_pin;
    @(posedge CLOCK) disable iff (RST)
    (accept & cfg_q.large_pkg) |=>
      EXTRA_LOW_BYTE_ADDR_PIN == ($past(cfg_q.mem8) & $past(REQ.addr[0]));
  endproperty
  a_extra_pin: assert property (p_extra_pin)
    else $error("extra low byte pin wrong");

  c_byte_wr:  cover property (@(posedge CLOCK) accept & REQ.wr & REQ.is_byte);
  c_rd_done:  cover property (@(posedge CLOCK) RD_VALID);
  c_hold:     cover property (@(posedge CLOCK) ADDR_OE_N);
  c_reject:   cover property (@(posedge CLOCK) reject);
endmodule

/* File: sim/emb_mem_model.sv */
/*
  far-side model: one x16 memory chip hanging on the lane strobes.
  assumes pins from emb_lane_ctrl; data lines carry no pull resistor.
*/
`timescale 1ns/1ps
module emb_mem_model
  import emb_pkg::*;
(
  // clock
  input  wire logic                clk,
  // pins from the interface
  input  wire logic [PIN_A_HI:0]   addr_pins,
  input  wire logic                upper_n,
  input  wire logic                lower_n,
  input  wire logic [DATA_W-1:0]   dout,
  input  wire logic [DATA_W-1:0]   oe_n,
  input  wire logic                keep,
  // resolved bus level
  output logic      [DATA_W-1:0]   bus
);
  logic [DATA_W-1:0] mem [0:15];
  logic [DATA_W-1:0] last_q = '0;
  logic              rd_drv;
  logic [3:0]        idx;
  assign idx = addr_pins[4:1];
  // chip drives while any lane strobe is low and the interface is quiet
  assign rd_drv = !(upper_n && lower_n) && (&oe_n);
  always_comb begin
    for (int i = 0; i < DATA_W; i++) begin
      if (!oe_n[i])
        bus[i] = dout[i];
      else if (rd_drv)
        bus[i] = mem[idx][i];
      else if (keep)
        bus[i] = last_q[i];
      else
        bus[i] = ~last_q[i];
    end
  end
  always_ff @(posedge clk) begin
    last_q <= bus;
    if (!lower_n && !oe_n[0])
      mem[idx][7:0] <= dout[7:0];
    if (!upper_n && !oe_n[8])
      mem[idx][15:8] <= dout[15:8];
  end
endmodule

/* File: sim/tb_ext_mem_byte_lane_addr_map.sv */
/*
  testbench for emb_lane_ctrl with a memory chip model on its pins.
  assumes the register map and latencies of emb_lane_ctrl.
*/
`timescale 1ns/1ps
module tb_ext_mem_byte_lane_addr_map
  import emb_pkg::*;
;
  logic clk = 0, rst = 1, rwr = 0, rrd = 0, rej, rdv, ext, aoe, soe;
  logic un, ln, keep;
  logic [1:0]  radr = '0;
  logic [7:0]  rwd = '0, rdat;
  logic [15:0] rd_data, dout, oe_n, bus;
  logic [20:0] pins;
  emb_req_t    req = '0;
  int          error_cnt = 0, n_compared = 0, cyc = 0;
  localparam logic [20:0] MAP_A = 21'h16a52;

  always #5 clk = ~clk;

  emb_lane_ctrl u_dut (.CLOCK(clk), .RST(rst), .REG_ADDR(radr),
    .REG_WDATA(rwd), .REG_WR(rwr), .REG_RD(rrd), .REG_RDATA(rdat),
    .REQ(req), .REQ_REJECT(rej), .RD_DATA(rd_data), .RD_VALID(rdv),
    .ADDR_PINS(pins), .EXTRA_LOW_BYTE_ADDR_PIN(ext), .ADDR_OE_N(aoe),
    .UPPER_LANE_STROBE_N(un), .LOWER_LANE_STROBE_N(ln),
    .STROBE_OE_N(soe), .DATA_OUT(dout), .DATA_OE_N(oe_n),
    .DATA_IN(bus), .KEEPER_EN(keep));

  emb_mem_model u_mem (.clk(clk), .addr_pins(pins), .upper_n(un),
    .lower_n(ln), .dout(dout), .oe_n(oe_n), .keep(keep), .bus(bus));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic report_and_stop;
    if (error_cnt == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    radr <= a;
    rwd <= d;
    rwr <= 1'b1;
    @(posedge clk);
    rwr <= 1'b0;
    #1;
  endtask

  task automatic reg_chk(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk);
    radr <= a;
    rrd <= 1'b1;
    @(posedge clk);
    rrd <= 1'b0;
    #1;
    chk(rdat, exp);
  endtask

  task automatic do_req(input logic w, b, s, input logic [20:0] a,
                        input logic [15:0] d);
    @(posedge clk);
    req <= '{go: 1'b1, wr: w, is_byte: b, sdram: s, addr: a, wdata: d};
    @(posedge clk);
    req.go <= 1'b0;
    #1;
  endtask

  task automatic rd_byte(input logic [20:0] a, input logic [15:0] exp);
    do_req(1'b0, 1'b1, 1'b0, a, 16'h0000);
    chk({un, ln, oe_n}, {2'h0, 16'hffff});
    repeat (3) @(posedge clk);
    #1;
    chk({rdv, rd_data}, {1'b1, exp});
  endtask

  function automatic logic [21:0] exp_map(input logic lg, m8,
                                          input logic [20:0] a);
    if (!lg)
      return {1'b0, 7'h00, a[13:1], m8 ? a[0] : a[14]};
    return {m8 & a[0], a[20:1], 1'b0};
  endfunction

  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk({un, ln, oe_n}, {2'h3, 16'hffff});
    reg_wr(2'h1, 8'h08);
    chk(keep, 1'b1);
    reg_chk(2'h1, 8'h08);
    do_req(1'b1, 1'b0, 1'b0, 21'h10, 16'hb7a5);
    chk({un, ln, oe_n, dout}, {2'h0, 16'h0000, 16'hb7a5});
    @(posedge clk);
    #1;
    chk({un, ln, oe_n}, {2'h3, 16'hffff});
    do_req(1'b1, 1'b1, 1'b0, 21'h12, 16'h003c);
    chk({un, ln, oe_n, dout[7:0]}, {2'h2, 16'hff00, 8'h3c});
    do_req(1'b1, 1'b1, 1'b0, 21'h13, 16'h00c3);
    chk({un, ln, oe_n, dout[15:8]}, {2'h1, 16'h00ff, 8'hc3});
    rd_byte(21'h11, 16'h00b7);
    rd_byte(21'h12, 16'h003c);
    rd_byte(21'h13, 16'h00c3);
    reg_wr(2'h1, 8'h00);
    chk(keep, 1'b0);
    for (int i = 0; i < 4; i++) begin
      reg_wr(2'h1, {6'h00, i[1], i[0]});
      do_req(1'b0, 1'b0, 1'b0, MAP_A, 16'h0000);
      chk({ext, pins}, exp_map(i[0], i[1], MAP_A));
      chk({un, ln}, i[1] ? 2'h2 : 2'h0);
    end
    do_req(1'b1, 1'b0, 1'b0, 21'h05, 16'h1234);
    chk({un, ln, oe_n, dout[7:0]}, {2'h2, 16'hff00, 8'h34});
    reg_wr(2'h1, 8'h06);
    do_req(1'b1, 1'b0, 1'b0, 21'h05, 16'h1234);
    chk({un, ln, rej}, 3'h7);
    reg_chk(2'h2, 8'h01);
    reg_wr(2'h0, 8'h02);
    @(posedge clk);
    #1;
    chk(rej, 1'b0);
    do_req(1'b0, 1'b0, 1'b1, 21'h05, 16'h0000);
    chk({un, ln, rej}, 3'h7);
    reg_wr(2'h0, 8'h02);
    do_req(1'b0, 1'b0, 1'b0, 21'h05, 16'h0000);
    chk({un, ln, rej}, 3'h4);
    reg_wr(2'h1, 8'h08);
    reg_wr(2'h0, 8'h01);
    chk({aoe, soe, keep}, 3'h6);
    do_req(1'b0, 1'b0, 1'b0, 21'h10, 16'h0000);
    chk({un, ln, oe_n, rej}, {2'h3, 16'hffff, 1'b1});
    reg_chk(2'h0, 8'h01);
    reg_wr(2'h0, 8'h02);
    chk({aoe, soe, keep}, 3'h1);
    reg_wr(2'h3, 8'hff);
    reg_chk(2'h3, 8'h00);
    reg_chk(2'h1, 8'h08);
    report_and_stop();
  end
endmodule
